// ### design/rke_pkg.sv
// Constants shared by the remote keyless entry body-control block.
// Assumes one 20 MHz system clock and a 1 ms timing tick derived from it.
package rke_pkg;

  // Clock and tick timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MS        = TICK_PERIOD_NS / 1000000;

  // Output timing, each in its own unit
  localparam int CHIRP_MS       = 50;
  localparam int FLASH_LONG_MS  = 1000;
  localparam int FLASH_SHORT_MS = 500;
  localparam int ACT_PULSE_MS   = 200;
  localparam int RELOCK_S       = 30;
  localparam int UNLOCK_FLASHES = 2;

  // Same timing as counts of ticks
  localparam int CHIRP_TICKS    = CHIRP_MS / TICK_MS;
  localparam int FLASH_LONG_TK  = FLASH_LONG_MS / TICK_MS;
  localparam int FLASH_SHORT_TK = FLASH_SHORT_MS / TICK_MS;
  localparam int ACT_TICKS      = ACT_PULSE_MS / TICK_MS;
  localparam int RELOCK_TICKS   = RELOCK_S * 1000 / TICK_MS;

  // Counter widths
  localparam int TMR_W = 17;
  localparam int HAZ_W = 11;

  // Register map (byte addresses)
  localparam logic [3:0] CTRL_OFF   = 4'h0;
  localparam logic [3:0] STATUS_OFF = 4'h4;

  // Control register fields and reset value
  localparam int         CTRL_EN_BIT     = 0;
  localparam int         CTRL_CENTER_BIT = 1;
  localparam logic [1:0] CTRL_RESET      = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Body-control sequence states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_LOCK   = 4'h2,
    ST_WATCH  = 4'h4,
    ST_RELOCK = 4'h8
  } rke_state_e;

endpackage

// ### design/rke_ctrl.sv
// Remote keyless entry body control: lock/unlock relays, hazard, horn,
// room lamp, auto-relock timer, and an AXI4-Lite register slave.
// Assumes remote commands arrive as one-cycle pulses synchronous to aclk.
`timescale 1ns/1ps
module rke_ctrl
  import rke_pkg::*;
#(
  parameter int ADDR_W       = 4,
  parameter int TICK_DIV     = TICK_CYCLES,
  parameter int RELOCK_COUNT = RELOCK_TICKS
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Decoded remote commands
  input  wire logic              remote_lock_cmd,
  input  wire logic              remote_unlock_cmd,
  // Body switches
  input  wire logic              door_open,
  input  wire logic              hood_open,
  input  wire logic              tailgate_open,
  input  wire logic              key_present_switch,
  input  wire logic              ignition_line_one,
  input  wire logic              ignition_line_two,
  // Relay and lamp drives
  output logic                   lock_out,
  output logic                   unlock_out,
  output logic                   hazard_out,
  output logic                   horn_out,
  output logic                   room_lamp_out,
  output logic                   alarm_armed
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam logic [TMR_W-1:0] RELOCK_LD = TMR_W'(RELOCK_COUNT);
  localparam logic [TMR_W-1:0] TMR_MAX   = '1;

  logic [31:0]       tick_cnt_reg;
  logic              tick_reg;
  rke_state_e        state_reg;
  logic [TMR_W-1:0]  relock_cnt_reg;
  logic [HAZ_W-1:0]  act_cnt_reg;
  logic [HAZ_W-1:0]  horn_cnt_reg;
  logic [HAZ_W-1:0]  haz_cnt_reg;
  logic [HAZ_W-1:0]  haz_len_reg;
  logic [1:0]        haz_left_reg;
  logic [1:0]        ctrl_reg;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              any_open;
  logic              key_or_ign;
  logic              cmd_ok;
  logic              lock_acc;
  logic              unl_acc;
  logic              confirm;
  logic              close_evt;
  logic              relock_due;
  logic              horn_go;
  logic [TMR_W:0]    ext_sum;

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider: one-cycle pulse every TICK_DIV clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 32'(TICK_DIV - 1)) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode; lock wins over unlock when both arrive together
  always_comb begin
    any_open   = door_open | hood_open | tailgate_open;
    key_or_ign = key_present_switch | ignition_line_one | ignition_line_two;
    cmd_ok     = ctrl_reg[CTRL_EN_BIT] & ~key_present_switch;
    lock_acc   = remote_lock_cmd & cmd_ok;
    unl_acc    = remote_unlock_cmd & ~remote_lock_cmd & cmd_ok;
    confirm    = (state_reg == ST_LOCK) & ~lock_out & ~lock_acc & ~unl_acc;
    close_evt  = (state_reg == ST_WATCH) & ~any_open & ~lock_acc & ~unl_acc;
    relock_due = (state_reg == ST_RELOCK) & ~door_open & ~key_or_ign & ~lock_acc
                 & ~unl_acc & tick_reg & (relock_cnt_reg == TMR_W'(1));
    horn_go    = confirm | close_evt | relock_due;
    ext_sum    = {1'b0, relock_cnt_reg} + {1'b0, RELOCK_LD};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state, relock timer, room lamp and alarm arming
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= ST_IDLE;
      relock_cnt_reg <= '0;
      room_lamp_out  <= 1'b0;
      alarm_armed    <= 1'b0;
    end else if (lock_acc) begin
      state_reg      <= any_open ? ST_WATCH : ST_LOCK;
      relock_cnt_reg <= '0;
      room_lamp_out  <= 1'b0;
    end else if (unl_acc) begin
      state_reg     <= ST_RELOCK;
      alarm_armed   <= 1'b0;
      room_lamp_out <= ctrl_reg[CTRL_CENTER_BIT];
      if (state_reg == ST_RELOCK) begin
        // Saturate so that many presses cannot wrap to a short window
        relock_cnt_reg <= ext_sum[TMR_W] ? TMR_MAX : ext_sum[TMR_W-1:0];
      end else begin
        relock_cnt_reg <= RELOCK_LD;
      end
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_LOCK: begin
          if (confirm) begin
            state_reg   <= ST_IDLE;
            alarm_armed <= 1'b1;
          end
        end
        ST_WATCH: begin
          if (close_evt) begin
            state_reg   <= ST_IDLE;
            alarm_armed <= 1'b1;
          end
        end
        ST_RELOCK: begin
          if (key_or_ign || door_open) begin
            state_reg      <= ST_IDLE;
            relock_cnt_reg <= '0;
            room_lamp_out  <= 1'b0;
          end else if (relock_due) begin
            state_reg      <= ST_IDLE;
            relock_cnt_reg <= '0;
            room_lamp_out  <= 1'b0;
            alarm_armed    <= 1'b1;
          end else if (tick_reg) begin
            relock_cnt_reg <= relock_cnt_reg - TMR_W'(1);
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock and unlock relays: fixed-length pulse, new command restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_out    <= 1'b0;
      unlock_out  <= 1'b0;
      act_cnt_reg <= '0;
    end else if (lock_acc || relock_due) begin
      lock_out    <= 1'b1;
      unlock_out  <= 1'b0;
      act_cnt_reg <= HAZ_W'(ACT_TICKS);
    end else if (unl_acc) begin
      lock_out    <= 1'b0;
      unlock_out  <= 1'b1;
      act_cnt_reg <= HAZ_W'(ACT_TICKS);
    end else if (tick_reg && act_cnt_reg != '0) begin
      act_cnt_reg <= act_cnt_reg - HAZ_W'(1);
      if (act_cnt_reg == HAZ_W'(1)) begin
        lock_out   <= 1'b0;
        unlock_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Horn chirp; a fresh lock silences any chirp still running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      horn_out     <= 1'b0;
      horn_cnt_reg <= '0;
    end else if (lock_acc) begin
      horn_out     <= 1'b0;
      horn_cnt_reg <= '0;
    end else if (horn_go) begin
      horn_out     <= 1'b1;
      horn_cnt_reg <= HAZ_W'(CHIRP_TICKS);
    end else if (tick_reg && horn_cnt_reg != '0) begin
      horn_cnt_reg <= horn_cnt_reg - HAZ_W'(1);
      if (horn_cnt_reg == HAZ_W'(1)) begin
        horn_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hazard flasher: on and off phases of equal length, haz_left more flashes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hazard_out   <= 1'b0;
      haz_cnt_reg  <= '0;
      haz_len_reg  <= '0;
      haz_left_reg <= '0;
    end else if (lock_acc) begin
      hazard_out   <= 1'b0;
      haz_cnt_reg  <= '0;
      haz_left_reg <= '0;
    end else if (unl_acc) begin
      hazard_out   <= 1'b1;
      haz_cnt_reg  <= HAZ_W'(FLASH_SHORT_TK);
      haz_len_reg  <= HAZ_W'(FLASH_SHORT_TK);
      haz_left_reg <= 2'(UNLOCK_FLASHES - 1);
    end else if (confirm || close_evt) begin
      hazard_out   <= 1'b1;
      haz_cnt_reg  <= confirm ? HAZ_W'(FLASH_LONG_TK) : HAZ_W'(CHIRP_TICKS);
      haz_len_reg  <= confirm ? HAZ_W'(FLASH_LONG_TK) : HAZ_W'(CHIRP_TICKS);
      haz_left_reg <= 2'h0;
    end else if (tick_reg && haz_cnt_reg != '0) begin
      haz_cnt_reg <= haz_cnt_reg - HAZ_W'(1);
      if (haz_cnt_reg == HAZ_W'(1)) begin
        if (hazard_out) begin
          hazard_out  <= 1'b0;
          haz_cnt_reg <= (haz_left_reg != 2'h0) ? haz_len_reg : HAZ_W'(0);
        end else begin
          hazard_out   <= 1'b1;
          haz_left_reg <= haz_left_reg - 2'h1;
          haz_cnt_reg  <= haz_len_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order, then response
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= 32'h0;
      wstrb_reg    <= 4'h0;
      ctrl_reg     <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (aw_hold_reg && w_hold_reg) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status is read-only, so a write there is refused like a hole
        if (awaddr_reg[ADDR_W-1:2] == CTRL_OFF[3:2]) begin
          s_axi_bresp <= RESP_OKAY;
          if (wstrb_reg[0]) begin
            ctrl_reg <= wdata_reg[1:0];
          end
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one-cycle answer after the address is taken
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr[ADDR_W-1:2])
        CTRL_OFF[3:2]:   s_axi_rdata <= {30'h0, ctrl_reg};
        STATUS_OFF[3:2]: s_axi_rdata <= {22'h0, alarm_armed, room_lamp_out, horn_out,
                                         hazard_out, unlock_out, lock_out, state_reg};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks: helper counts ticks while the horn sounds
  logic [HAZ_W-1:0] horn_ticks_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || horn_go || !horn_out) begin
      horn_ticks_reg <= '0;
    end else if (tick_reg) begin
      horn_ticks_reg <= horn_ticks_reg + HAZ_W'(1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_lock_confirm: assert property (confirm |=> horn_out && hazard_out && alarm_armed)
    else $error("lock confirm did not start chirp and flash");
  chk_open_silent: assert property (lock_acc && any_open |=> lock_out && !horn_out
                                    && !hazard_out && state_reg == ST_WATCH)
    else $error("lock with an opening open was not silent");
  chk_close_chirp: assert property (close_evt |=> horn_out && hazard_out)
    else $error("closing after open lock gave no chirp");
  chk_auto_relock: assert property (relock_due |=> lock_out && horn_out && !room_lamp_out
                                    && alarm_armed)
    else $error("relock expiry did not lock and chirp");
  chk_relock_extend: assert property (unl_acc && state_reg == ST_RELOCK
                                      && relock_cnt_reg < TMR_W'(RELOCK_COUNT)
                                      |=> relock_cnt_reg == $past(relock_cnt_reg)
                                      + TMR_W'(RELOCK_COUNT))
    else $error("second unlock did not extend relock window");
  chk_key_clear: assert property (state_reg == ST_RELOCK && key_or_ign && !unl_acc
                                  && !lock_acc |=> state_reg == ST_IDLE
                                  && relock_cnt_reg == '0 && !$rose(lock_out))
    else $error("key or ignition did not clear relock timer");
  chk_unlock_flash: assert property (unl_acc |=> unlock_out && hazard_out
                                     && haz_left_reg == 2'(UNLOCK_FLASHES - 1))
    else $error("unlock did not drive relay and two flashes");
  chk_key_ignore: assert property (key_present_switch |=> !$rose(lock_out)
                                   && !$rose(unlock_out))
    else $error("relay moved while key present");
  chk_lamp_on: assert property (unl_acc && ctrl_reg[CTRL_CENTER_BIT] |=> room_lamp_out)
    else $error("room lamp not lit at unlock");
  chk_lamp_off: assert property (lock_acc |=> !room_lamp_out)
    else $error("room lamp not cut at lock");
  chk_chirp_len: assert property (horn_out && tick_reg && horn_cnt_reg == HAZ_W'(1)
                                  && !lock_acc && !horn_go
                                  |-> horn_ticks_reg == HAZ_W'(CHIRP_TICKS - 1))
    else $error("horn chirp length wrong");
  chk_tick_pulse: assert property (tick_reg |=> !tick_reg)
    else $error("tick longer than one cycle");

  // The relay pulse outlasts a short window, so reach for 1000 cycles
  cov_lock_closed: cover property (lock_acc && !any_open ##[1:1000] confirm);
  cov_lock_open:   cover property (state_reg == ST_WATCH && any_open ##1 close_evt);
  cov_relock:      cover property (relock_due);
  cov_extend:      cover property (unl_acc && state_reg == ST_RELOCK);

endmodule

// ### testbench/rke_rf_model.sv
// RF receiver model: turns bench requests into decoded remote command pulses.
// Assumes the controller samples the commands on the rising edge of aclk.
`timescale 1ns/1ps
module rke_rf_model (
  // Clock
  input  wire logic aclk,
  // Decoded commands
  output logic      remote_lock_cmd,
  output logic      remote_unlock_cmd
);
  ////////////////////////////////////////////////////////////
  // Both command lines rest low between received frames
  initial begin
    remote_lock_cmd   = 1'b0;
    remote_unlock_cmd = 1'b0;
  end

  // One frame gives a single-cycle pulse; lock wins if both buttons are held
  task automatic send(input logic lk, input logic ul);
    @(posedge aclk);
    remote_lock_cmd   <= lk;
    remote_unlock_cmd <= ul & ~lk;
    @(posedge aclk);
    remote_lock_cmd   <= 1'b0;
    remote_unlock_cmd <= 1'b0;
  endtask
endmodule

// ### testbench/test_rke_ctrl.sv
// Self-checking bench for the keyless entry controller: registers over
// AXI4-Lite, then the lock, unlock and relock sequences at the pins.
// Assumes rke_rf_model supplies the command pulses; counts are shortened.
`timescale 1ns/1ps
module test_rke_ctrl;
  import rke_pkg::*;
  localparam int DIV = 4;     // Clocks per tick, kept short for run time
  localparam int RLK = 1600;  // Relock ticks, outlasting the flash sequence
  typedef struct {
    string       nm;
    logic [33:0] ex;
  } rke_note_s;
  logic            aclk, aresetn, snap;
  logic [3:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [1:0]      bresp, rresp;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, lk_cmd, ul_cmd;
  logic [2:0]      opening;   // Door, hood, tailgate
  logic [2:0]      sw;        // Key, ignition one, ignition two
  logic [5:0]      pins;      // Alarm, lamp, horn, hazard, unlock, lock
  int              failures, compares, cycles, seed, i;
  rke_note_s       notes[$];

  ////////////////////////////////////////////////////////////
  // Design and far-side model
  rke_ctrl #(.TICK_DIV(DIV), .RELOCK_COUNT(RLK)) i_rke_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .remote_lock_cmd(lk_cmd), .remote_unlock_cmd(ul_cmd),
    .door_open(opening[0]), .hood_open(opening[1]), .tailgate_open(opening[2]),
    .key_present_switch(sw[0]), .ignition_line_one(sw[1]),
    .ignition_line_two(sw[2]),
    .lock_out(pins[0]), .unlock_out(pins[1]), .hazard_out(pins[2]),
    .horn_out(pins[3]), .room_lamp_out(pins[4]), .alarm_armed(pins[5])
  );
  rke_rf_model i_rke_rf_model (
    .aclk(aclk), .remote_lock_cmd(lk_cmd), .remote_unlock_cmd(ul_cmd)
  );

  ////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs about 60000 cycles
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////
  // Comparison, verdict and result watcher
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // An empty queue pops an unknown note, so a stray result still fails
  task automatic retire(input logic [33:0] seen);
    rke_note_s n;
    n = notes.pop_front();
    check(n.nm, seen, n.ex);
  endtask

  always @(posedge aclk) begin
    if (snap) retire({28'h0, pins});
    if (bvalid && bready) retire({bresp, 32'h0});
    if (rvalid && rready) retire({rresp, rdata});
  end

  ////////////////////////////////////////////////////////////
  // Driver tasks; each notes its expectation before the result can appear
  task automatic wt(input int ticks);
    repeat (ticks * DIV) @(posedge aclk);
  endtask

  task automatic see(input string nm, input logic [5:0] e);
    notes.push_back('{nm, {28'h0, e}});
    snap <= 1'b1;
    @(posedge aclk);
    snap <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bit got_a;
    bit got_w;
    got_a = 1'b0;
    got_w = 1'b0;
    notes.push_back('{"write response", {r, 32'h0}});
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(got_a && got_w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        got_a = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        got_w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    // Let an edge pass so a following call never reassigns bready at once
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    notes.push_back('{"read response and data", e});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    // Let an edge pass so a following call never reassigns rready at once
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {aresetn, snap, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, opening, sw} = '0;
    {failures, compares, cycles, i} = '0;
    seed = 6;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Register map, holes, read-only place and the enable bit
    rd(CTRL_OFF, {RESP_OKAY, 30'h0, CTRL_RESET});
    rd(STATUS_OFF, {RESP_OKAY, 32'h1});
    wr(STATUS_OFF, $random(seed), RESP_SLVERR);
    wr(4'h8, $random(seed), RESP_SLVERR);
    rd(4'hc, {RESP_SLVERR, 32'h0});
    wr(CTRL_OFF, $random(seed) & 32'hffff_fffc, RESP_OKAY);
    rd(CTRL_OFF, {RESP_OKAY, 32'h0});
    i_rke_rf_model.send(1'b0, 1'b1);
    wt(10);
    see("commands disabled", 6'h00);
    wr(CTRL_OFF, 32'h1, RESP_OKAY);
    i_rke_rf_model.send(1'b0, 1'b1);
    wt(100);
    see("lamp switch off", 6'b000110);
    sw <= 3'b001;
    wt(1700);
    see("key clears timer", 6'h00);
    sw <= 3'b000;
    wr(CTRL_OFF, 32'h3, RESP_OKAY);
    $display("test registers done");
    // Unlock, two short flashes, then automatic relock with one chirp
    i_rke_rf_model.send(1'b0, 1'b1);
    wt(100);
    see("unlock first flash", 6'b010110);
    wt(200);
    see("unlock relay ended", 6'b010100);
    wt(450);
    see("flash gap", 6'b010000);
    wt(500);
    see("second flash", 6'b010100);
    wt(390);
    see("relock chirp", 6'b101001);
    wt(20);
    see("chirp ended", 6'b100001);
    wt(250);
    see("relock ended", 6'b100000);
    $display("test relock done");
    // Second unlock adds a full window to the time left
    i_rke_rf_model.send(1'b0, 1'b1);
    wt(1000);
    i_rke_rf_model.send(1'b0, 1'b1);
    wt(700);
    see("window extended", 6'b010000);
    wt(1510);
    see("extended relock", 6'b101001);
    wt(250);
    see("extended relock ended", 6'b100000);
    $display("test extend done");
    // Key and each ignition line clear a running timer
    for (i = 0; i < 3; i++) begin
      i_rke_rf_model.send(1'b0, 1'b1);
      wt(1000);
      sw <= 3'b001 << i;
      wt(800);
      see("switch clears timer", 6'h00);
      sw <= 3'b000;
    end
    $display("test timer clear done");
    // Lock with one opening open, then the opening closes
    opening <= 3'b001 << ($unsigned($random(seed)) % 3);
    i_rke_rf_model.send(1'b1, 1'b0);
    wt(100);
    see("lock while open", 6'b000001);
    wt(200);
    see("watching opening", 6'h00);
    opening <= 3'b000;
    wt(10);
    see("closed chirp", 6'b101100);
    wt(60);
    see("closed chirp ended", 6'b100000);
    $display("test open lock done");
    // Lock inside the relock window, then the confirmation
    i_rke_rf_model.send(1'b0, 1'b1);
    wt(1000);
    i_rke_rf_model.send(1'b1, 1'b0);
    wt(2);
    see("lamp off at lock", 6'b000001);
    wt(220);
    see("lock confirmed", 6'b101100);
    wt(40);
    see("lock chirp ended", 6'b100100);
    wt(920);
    see("long flash held", 6'b100100);
    wt(40);
    see("long flash ended", 6'b100000);
    $display("test lock done");
    // Key present: remote commands move nothing
    sw <= 3'b001;
    i_rke_rf_model.send(1'b0, 1'b1);
    i_rke_rf_model.send(1'b1, 1'b0);
    wt(10);
    see("key present", 6'b100000);
    sw <= 3'b000;
    $display("test key present done");
    test_done();
  end
endmodule
